/* File: logic/dafe_encoder.sv */
// Diagnosis alarm field encoder with an Avalon-MM register slave
`timescale 1ns/100ps
`include "dafe_map.svh"
module dafe_encoder (
    input wire logic clk,
    input wire logic arst_n,
    input wire dafe_pkg::dafe_avl_req_s avl_req,
    output dafe_pkg::dafe_avl_rsp_s avl_rsp,
    output dafe_pkg::dafe_fields_s fields,
    output logic fields_valid
);
    import dafe_pkg::*;

    dafe_state_s s_q;
    dafe_state_s s_d;
    logic [15:0] chan_num;
    logic [7:0] prop_type;

    // Channel number chosen from the configured port mode and event kind
    always_comb begin
        chan_num = `DAFE_CHAN_SUPPLY;
        case (s_q.event_kind)
            DAFE_EV_US_UNDER, DAFE_EV_UA_UNDER,
            DAFE_EV_UA_MISSING: chan_num = `DAFE_CHAN_SUPPLY;
            DAFE_EV_SHORT: begin
                if (s_q.port_is_p2p) begin
                    chan_num = `DAFE_CHAN_PORT_ITSELF;
                end else begin
                    chan_num = {12'h000, s_q.port};
                end
            end
            DAFE_EV_LINE_BREAK,
            DAFE_EV_BAD_CONFIG: chan_num = `DAFE_CHAN_PORT_ITSELF;
            DAFE_EV_DEVICE: chan_num = `DAFE_CHAN_DEVICE;
            default: chan_num = `DAFE_CHAN_SUPPLY;
        endcase
    end

    // Supply channel forces a type of none, whatever width was asked
    always_comb begin
        prop_type = `DAFE_TYPE_NONE;
        if (chan_num != `DAFE_CHAN_SUPPLY) begin
            case (s_q.width_sel)
                2'h1: prop_type = `DAFE_TYPE_1BIT;
                2'h2: prop_type = `DAFE_TYPE_2BIT;
                default: prop_type = `DAFE_TYPE_NONE;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.fields_valid = 1'b0;
        if ((avl_req.read || avl_req.write) && !s_q.ack) begin
            // One wait state per access keeps read data registered
            s_d.ack = 1'b1;
            s_d.rdata = 32'h0000_0000;
        end
        // Writes land only at the edge where waitrequest is seen low
        if (avl_req.write && s_q.ack) begin
                case (avl_req.address)
                    `DAFE_REG_CTRL: begin
                        s_d.chan_pend = avl_req.writedata[0];
                        s_d.manuf_pend = avl_req.writedata[1];
                        s_d.submod_more = avl_req.writedata[2];
                        s_d.module_more = avl_req.writedata[3];
                        s_d.port_is_p2p = avl_req.writedata[4];
                        s_d.width_sel = avl_req.writedata[9:8];
                    end
                    `DAFE_REG_SUBMOD: s_d.submod_id = avl_req.writedata;
                    `DAFE_REG_EVENT: begin
                        s_d.port = avl_req.writedata[3:0];
                        s_d.event_kind = dafe_event_e'(avl_req.writedata[6:4]);
                        s_d.fields_valid = 1'b1;
                    end
                    default: s_d.rdata = s_q.rdata;
                endcase
        end
        if (avl_req.read && !avl_req.write && !s_q.ack) begin
                case (avl_req.address)
                    `DAFE_REG_CTRL: s_d.rdata = {22'h000000, s_q.width_sel,
                        3'h0, s_q.port_is_p2p, s_q.module_more,
                        s_q.submod_more, s_q.manuf_pend, s_q.chan_pend};
                    `DAFE_REG_SUBMOD: s_d.rdata = s_q.submod_id;
                    `DAFE_REG_EVENT: s_d.rdata = {25'h0000000,
                        s_q.event_kind, s_q.port};
                    `DAFE_REG_SPEC: s_d.rdata = {16'h0000,
                        s_q.fields.alarm_spec};
                    `DAFE_REG_FIELDS: s_d.rdata = {s_q.fields.user_struct_id,
                        s_q.fields.channel_number};
                    `DAFE_REG_PROPS: s_d.rdata = {16'h0000,
                        s_q.fields.channel_props};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
        end
        // Event write launches one message; latched fields then stay stable
        if (s_q.fields_valid) begin
            s_d.seq = s_q.seq + 11'h001;
        end
        if (s_d.fields_valid) begin
            s_d.fields.submodule_id = s_q.submod_id;
            s_d.fields.alarm_spec[`DAFE_SEQ_W-1:0] = s_q.seq;
            s_d.fields.alarm_spec[`DAFE_BIT_CHAN] = s_q.chan_pend;
            s_d.fields.alarm_spec[`DAFE_BIT_MANUF] = s_q.manuf_pend;
            s_d.fields.alarm_spec[`DAFE_BIT_SUBMOD] = s_q.submod_more;
            s_d.fields.alarm_spec[`DAFE_BIT_RSVD] = 1'b0;
            s_d.fields.alarm_spec[`DAFE_BIT_MODULE] = s_q.module_more;
            s_d.fields.user_struct_id = `DAFE_USER_STRUCT_CHAN;
        end
        if (s_q.fields_valid) begin
            // Port and event fields have settled one cycle after the write
            s_d.fields.channel_number = chan_num;
            s_d.fields.channel_props = {8'h00, prop_type};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.submod_id <= `DAFE_SUBMOD_ID_RST;
            s_q.event_kind <= DAFE_EV_US_UNDER;
        end else begin
            s_q <= s_d;
        end
    end

    assign avl_rsp.waitrequest = (avl_req.read || avl_req.write) && !s_q.ack;
    assign avl_rsp.readdata = s_q.rdata;
    assign fields = s_q.fields;
    // Strobe one cycle after field latch so channel fields are complete
    logic fv_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fv_q <= 1'b0;
        end else begin
            fv_q <= s_q.fields_valid;
        end
    end
    assign fields_valid = fv_q;
endmodule : dafe_encoder

/* File: shared/dafe_map.svh */
// Field layouts, codes and register offsets of the diagnosis alarm encoder
// Contract
// - The message carries a 4-byte submodule identifier field naming the submodule in use.
// - Bits 0 to 10 of the 2-byte alarm specifier hold a sequence counter that advances by one per new message.
// - Alarm specifier bit 11 is 1 while a channel-related diagnosis is pending and 0 otherwise.
// - Alarm specifier bit 12 is 1 while a manufacturer-specific diagnosis is pending and 0 otherwise.
// - Alarm specifier bit 13 is 1 when a further diagnosis of the submodule is present and 0 otherwise.
// - Alarm specifier bit 15 is 1 when a further diagnosis of the module is present, and bit 14 is reserved.
// - The 2-byte user structure identifier is 0x8000 for channel-related diagnosis.
// - In standard I/O, supply undervoltages and missing actuator supply use channel number 8000.
// - In standard I/O, sensor and actuator short circuits use channel number 0n with n the port.
// - In point-to-point port mode, line break, port shorts and wrong device configuration use channel 0.
// - Diagnostics raised by an attached point-to-point device use channel 1.
// - Channel properties type is 0x00 for channel 0x8000 or no type, 0x01 for 1 bit, 0x02 for 2 bit.
`ifndef DAFE_MAP_SVH
`define DAFE_MAP_SVH
`define DAFE_SEQ_W 11
`define DAFE_BIT_CHAN 11
`define DAFE_BIT_MANUF 12
`define DAFE_BIT_SUBMOD 13
`define DAFE_BIT_RSVD 14
`define DAFE_BIT_MODULE 15
`define DAFE_USER_STRUCT_CHAN 16'h8000
`define DAFE_CHAN_SUPPLY 16'h8000
`define DAFE_CHAN_PORT_ITSELF 16'h0000
`define DAFE_CHAN_DEVICE 16'h0001
`define DAFE_TYPE_NONE 8'h00
`define DAFE_TYPE_1BIT 8'h01
`define DAFE_TYPE_2BIT 8'h02
`define DAFE_SUBMOD_ID_RST 32'h0000_0A5A
`define DAFE_REG_CTRL 6'h00
`define DAFE_REG_SUBMOD 6'h04
`define DAFE_REG_EVENT 6'h08
`define DAFE_REG_SPEC 6'h0C
`define DAFE_REG_FIELDS 6'h10
`define DAFE_REG_PROPS 6'h14
`endif

/* File: shared/dafe_pkg.sv */
// Types shared by the diagnosis alarm encoder
package dafe_pkg;
    typedef enum logic [2:0] {
        DAFE_EV_US_UNDER,
        DAFE_EV_UA_UNDER,
        DAFE_EV_UA_MISSING,
        DAFE_EV_SHORT,
        DAFE_EV_LINE_BREAK,
        DAFE_EV_BAD_CONFIG,
        DAFE_EV_DEVICE
    } dafe_event_e;

    typedef struct packed {
        logic [31:0] submodule_id;
        logic [15:0] alarm_spec;
        logic [15:0] user_struct_id;
        logic [15:0] channel_number;
        logic [15:0] channel_props;
    } dafe_fields_s;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } dafe_avl_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } dafe_avl_rsp_s;

    typedef struct packed {
        logic [10:0] seq;
        logic chan_pend;
        logic manuf_pend;
        logic submod_more;
        logic module_more;
        logic port_is_p2p;
        logic [3:0] port;
        dafe_event_e event_kind;
        logic [1:0] width_sel;
        logic [31:0] submod_id;
        dafe_fields_s fields;
        logic fields_valid;
        logic ack;
        logic [31:0] rdata;
    } dafe_state_s;
endpackage : dafe_pkg

/* File: dv/dafe_encoder_assertions.sv */
// Port checks for the diagnosis alarm encoder
`timescale 1ns/100ps
module dafe_encoder_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire dafe_pkg::dafe_avl_req_s avl_req,
    input wire dafe_pkg::dafe_avl_rsp_s avl_rsp,
    input wire dafe_pkg::dafe_fields_s fields,
    input wire logic fields_valid
);
    import dafe_pkg::*;
    logic [10:0] seq_q;
    logic seen_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_q <= 11'h000;
            seen_q <= 1'b0;
        end else if (fields_valid) begin
            seq_q <= fields.alarm_spec[10:0];
            seen_q <= 1'b1;
        end
    end
    sequence s_event_taken;
        avl_req.write && avl_req.address == 6'h08 && !avl_rsp.waitrequest;
    endsequence
    AST_LAUNCH: assert property (s_event_taken |-> ##2 fields_valid)
        else $error("no message after event write");
    AST_PULSE: assert property (fields_valid |=> !fields_valid)
        else $error("valid pulse too long");
    AST_SEQ_STEP: assert property (fields_valid && seen_q |->
        fields.alarm_spec[10:0] == seq_q + 11'h001)
        else $error("sequence did not step by one");
    AST_SEQ_FIRST: assert property (fields_valid && !seen_q |->
        fields.alarm_spec[10:0] == 11'h000)
        else $error("first sequence not zero");
    AST_RSVD: assert property (fields_valid |-> !fields.alarm_spec[14])
        else $error("reserved spec bit set");
    AST_USID: assert property (fields_valid |->
        fields.user_struct_id == 16'h8000)
        else $error("wrong user structure id");
    AST_TYPE: assert property (fields_valid &&
        fields.channel_number == 16'h8000 |-> fields.channel_props[7:0] == 8'h00)
        else $error("supply channel with nonzero type");
    AST_CHAN_HOLD: assert property ($changed(fields.channel_number) |->
        fields_valid)
        else $error("channel changed outside a message");
endmodule : dafe_encoder_assertions
bind dafe_encoder dafe_encoder_assertions u_chk (.clk(clk), .arst_n(arst_n),
    .avl_req(avl_req), .avl_rsp(avl_rsp), .fields(fields),
    .fields_valid(fields_valid));

/* File: dv/dafe_alarm_sink.sv */
// Controller-side model that takes in each finished alarm message
`timescale 1ns/100ps
module dafe_alarm_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire dafe_pkg::dafe_fields_s fields,
    input wire logic fields_valid
);
    import dafe_pkg::*;
    dafe_fields_s last_q;
    // Only the pulse marks a whole message, so fields are taken then alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_q <= '0;
        end else if (fields_valid) begin
            last_q <= fields;
        end
    end
endmodule : dafe_alarm_sink

/* File: dv/tb_diag_alarm_field_encoder.sv */
// Directed bench for the diagnosis alarm encoder
`timescale 1ns/100ps
module tb_diag_alarm_field_encoder;
    import dafe_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    dafe_avl_req_s req = '0;
    dafe_avl_rsp_s rsp;
    dafe_fields_s fields;
    logic fields_valid;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [10:0] exp_seq = 11'h000;
    logic [31:0] rd;
    always #50 clk = ~clk;
    dafe_encoder dut (.clk(clk), .arst_n(arst_n), .avl_req(req),
        .avl_rsp(rsp), .fields(fields), .fields_valid(fields_valid));
    dafe_alarm_sink u_sink (.clk(clk), .arst_n(arst_n), .fields(fields),
        .fields_valid(fields_valid));
    task automatic end_sim;
        $display("Counts: %0d checks, %0d failures", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge clk);
        req.read <= !w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic msg(input logic [31:0] c, input int ev, input logic [3:0] p);
        logic [15:0] ch;
        logic [7:0] ty;
        bus(1'b1, 6'h00, c);
        bus(1'b1, 6'h08, {25'h0, ev[2:0], p});
        repeat (3) @(posedge clk);
        ch = ev < 3 ? 16'h8000 : ev == 3 ? (c[4] ? 16'h0000 : {12'h000, p})
            : ev == 6 ? 16'h0001 : 16'h0000;
        ty = ch == 16'h8000 || c[9:8] == 2'h3 ? 8'h00 : {6'h00, c[9:8]};
        chk("spec", {16'h0, c[3], 1'b0, c[2:0], exp_seq},
            {16'h0, u_sink.last_q.alarm_spec});
        chk("usid", 32'h8000, {16'h0, u_sink.last_q.user_struct_id});
        chk("chan", {16'h0, ch}, {16'h0, u_sink.last_q.channel_number});
        chk("type", {24'h0, ty}, {24'h0, u_sink.last_q.channel_props[7:0]});
        bus(1'b0, 6'h0C, 32'h0);
        chk("spec_reg", {16'h0, c[3], 1'b0, c[2:0], exp_seq}, rd);
        bus(1'b0, 6'h10, 32'h0);
        chk("fields_reg", {16'h8000, ch}, rd);
        exp_seq++;
    endtask : msg
    task automatic t_submod;
        bus(1'b0, 6'h04, 32'h0);
        chk("submod_rst", 32'h0000_0A5A, rd);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 6'h04, 32'h1234_5678);
        msg(32'h0, 1, 4'h0);
        chk("submod", 32'h1234_5678, u_sink.last_q.submodule_id);
        $display("t_submod done");
    endtask : t_submod
    task automatic t_codes;
        logic [31:0] cs [3] = '{32'h0000_0105, 32'h0000_020A, 32'h0000_031F};
        foreach (cs[i]) for (int ev = 0; ev < 7; ev++) msg(cs[i], ev, 4'h9);
        $display("t_codes done");
    endtask : t_codes
    task automatic t_wrap;
        for (int i = 0; i < 2050; i++) msg(32'h0000_0012, i % 7, 4'hF);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        exp_seq = 11'h000;
        msg(32'h0000_0001, 3, 4'h2);
        $display("t_wrap done");
    endtask : t_wrap
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_submod();
        t_codes();
        t_wrap();
        end_sim();
    end
endmodule : tb_diag_alarm_field_encoder
